// ==== common/dac_port_pkg.sv ====
// Constants for the serial converter write port
package dac_port_pkg;
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned DATA_BITS   = 14;
  localparam int unsigned MODE_BITS   = 2;
  localparam int unsigned COUNT_BITS  = 5;
  localparam logic [4:0]  COUNT_RESET = 5'h00;
  localparam logic [4:0]  COUNT_LAST  = 5'h10;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [13:0] VALUE_RESET = 14'h0000;
  localparam logic [1:0]  MODE_NORMAL = 2'h0;
  localparam logic [1:0]  MODE_RESET  = 2'h0;
  // Idle pin levels: select high, serial clock high, data low
  localparam logic [2:0]  PIN_IDLE    = 3'h6;
  // Host limit on serial clock rate, kept for reference by the bench
  localparam int unsigned SER_CLK_MAX_MHZ = 30;
  localparam int unsigned SYS_CLK_MHZ     = 20;
endpackage

// ==== core/dac_serial_write_port.sv ====
// Serial write port of a 14-bit converter, oversampled on the system clock
// Summary of operation
// - Frame select low opens frame, enables shifting
// - Data captured on serial clock falling edges
// - Shift register holds exactly sixteen bits
// - Sixteenth falling edge updates value and mode
// - Early frame select rise aborts, nothing changes
// - Two mode bits then fourteen data bits
// - Mode 00 normal, others power-down variants
// - Converter value zero after reset until write
// - Abort clears shift register and bit count
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port
  import dac_port_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        frameSelectN,
  input  wire logic        serialClk,
  input  wire logic        serial_data_in,
  output logic [13:0]      dacValue,
  output logic [1:0]       opMode,
  output logic             powerDown,
  output logic             updatePulse,
  output logic             abortPulse
);

  // Pin order in the synchroniser bank: select, serial clock, data
  wire [2:0] pinIn;
  wire [2:0] pinNow;
  wire [2:0] pinPrev;

  assign pinIn = {frameSelectN, serialClk, serial_data_in};

  // Two flops before any logic; the third only serves edge finding
  for (genvar p = 0; p < 3; p = p + 1) begin : g_sync
    logic [2:0] pipe_reg;

    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        pipe_reg <= {3{PIN_IDLE[p]}};
      end else begin
        pipe_reg <= {pipe_reg[1:0], pinIn[p]};
      end
    end

    assign pinNow[p]  = pipe_reg[1];
    assign pinPrev[p] = pipe_reg[2];
  end

  logic selN;
  logic selRise;
  logic clkFall;
  logic dataBit;

  assign selN    = pinNow[2];
  assign selRise = ~pinPrev[2] & pinNow[2];
  // Oversampled: each serial clock phase must last over one system clock,
  // so this port runs far below the pin rate limit
  assign clkFall = pinPrev[1] & ~pinNow[1];
  // Data read at the clock's depth so both line up on one edge
  assign dataBit = pinNow[0];

  typedef enum logic [1:0] {
    FRAME_IDLE,
    FRAME_SHIFT,
    FRAME_DONE
  } frame_e;

  frame_e      state_reg;
  frame_e      state_next;
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic [1:0]  frameMode;
  logic        takeBit;
  logic        lastBit;
  logic        earlyRise;

  assign takeBit   = (state_reg == FRAME_SHIFT) & ~selN & clkFall;
  assign lastBit   = takeBit & (count_reg == COUNT_LAST - 5'h01);
  // First two frame bits sit at the top once fifteen are in
  assign frameMode = shift_reg[14:13];
  // Select rising inside a started frame throws the frame away
  assign earlyRise = selRise & (state_reg == FRAME_SHIFT)
                   & (count_reg != COUNT_RESET);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FRAME_IDLE: begin
        if (!selN) begin
          state_next = FRAME_SHIFT;
        end
      end
      FRAME_SHIFT: begin
        if (selN) begin
          state_next = FRAME_IDLE;
        end else if (lastBit) begin
          state_next = FRAME_DONE;
        end
      end
      FRAME_DONE: begin
        // Clock edges land here and are dropped until select goes high
        if (selN) begin
          state_next = FRAME_IDLE;
        end
      end
      default: begin
        state_next = FRAME_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= FRAME_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shift_reg <= SHIFT_RESET;
      count_reg <= COUNT_RESET;
    end else if (state_reg != FRAME_SHIFT || selN) begin
      shift_reg <= SHIFT_RESET;
      count_reg <= COUNT_RESET;
    end else if (takeBit) begin
      shift_reg <= {shift_reg[14:0], dataBit};
      count_reg <= lastBit ? COUNT_RESET : count_reg + 5'h01;
    end
  end

  // Value, mode and power flag change together, only on a full frame
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dacValue  <= VALUE_RESET;
      opMode    <= MODE_RESET;
      powerDown <= (MODE_RESET != MODE_NORMAL);
    end else if (lastBit) begin
      opMode    <= frameMode;
      dacValue  <= {shift_reg[12:0], dataBit};
      powerDown <= (frameMode != MODE_NORMAL);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      updatePulse <= 1'b0;
      abortPulse  <= 1'b0;
    end else begin
      updatePulse <= lastBit;
      abortPulse  <= earlyRise;
    end
  end

endmodule
`default_nettype wire

// ==== tb/dac_serial_write_port_assertions.sv ====
// Checker on the write port outputs
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_assertions (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        frameSelectN,
  input wire logic [13:0] dacValue,
  input wire logic [1:0]  opMode,
  input wire logic        powerDown,
  input wire logic        updatePulse,
  input wire logic        abortPulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_update_once: assert property (updatePulse |=> !updatePulse)
    else $error("long update");
  a_value_load: assert property ($changed(dacValue) |-> updatePulse)
    else $error("stray value");
  a_mode_load: assert property ($changed(opMode) |-> updatePulse)
    else $error("stray mode");
  a_mode_power: assert property (powerDown == (opMode != 2'h0))
    else $error("power flag");
  a_abort_keep: assert property (abortPulse |-> $stable(dacValue))
    else $error("abort load");
  a_pulse_apart: assert property (!(updatePulse && abortPulse))
    else $error("both pulses");
  a_abort_high: assert property (abortPulse |-> frameSelectN)
    else $error("abort cause");
  a_reset_zero: assert property ($rose(rstn) |->
      dacValue == 14'h0000 && opMode == 2'h0 && !powerDown)
    else $error("reset value");
  sequence s_abort_seen;
    abortPulse;
  endsequence
  sequence s_value_held;
    $stable(dacValue) [*3];
  endsequence
  a_abort_hold: assert property (s_abort_seen |=> s_value_held)
    else $error("value moved after abort");
  a_update_gap: assert property (updatePulse |=> !updatePulse [*8])
    else $error("update too soon");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Host serial master model
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic frameSelectN,
  output logic serialClk,
  output logic serial_data_in
);
  initial {frameSelectN, serialClk, serial_data_in} = 3'h6;
  task automatic send(input logic [15:0] w, input int n);
    frameSelectN = 1'b0;
    // Clocks past the sixteenth resend the word inverted; n up to 32
    for (int k = 0; k < n; k++) begin
      serial_data_in = (k < 16) ? w[15 - k] : ~w[31 - k];
      #200 serialClk = 1'b0; // 2.5 MHz, well under limit
      #200 serialClk = 1'b1;
    end
    #200 frameSelectN = 1'b1;
    serial_data_in = ~serial_data_in; // Released line must not look held
    #400;
  endtask
endmodule
`default_nettype wire

// ==== tb/dac_serial_write_port_tb_top.sv ====
// Top bench for the converter write port
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_port_tb_top;
  logic sys_clk = 0, rstn = 0, fsN, sck, sdi, upd, abt, pd;
  logic [13:0] val;
  logic [1:0] md;
  int failures = 0, comparisons = 0;
  int updCount = 0, abortCount = 0;
  host_model host (.frameSelectN(fsN), .serialClk(sck), .serial_data_in(sdi));
  dac_serial_write_port dut (.sys_clk(sys_clk), .rstn(rstn),
    .frameSelectN(fsN), .serialClk(sck), .serial_data_in(sdi),
    .dacValue(val), .opMode(md), .powerDown(pd),
    .updatePulse(upd), .abortPulse(abt));
  initial forever #25 sys_clk = ~sys_clk;
  // Pulses counted on the falling edge, clear of the launching edge
  always @(negedge sys_clk) begin
    if (upd === 1'b1) updCount++;
    if (abt === 1'b1) abortCount++;
  end
  task chk(input logic [15:0] w);
    comparisons++;
    if (val !== w[13:0] || md !== w[15:14] || pd !== (w[15:14] != 2'h0)) begin
      failures++;
      $display("unexpected %0t frame result", $time);
    end
  endtask
  task chk_counts(input int u, input int a);
    comparisons++;
    if (updCount != u || abortCount != a) begin
      failures++;
      $display("unexpected %0t pulse count", $time);
    end
  endtask
  task end_of_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      host.send({m[1:0], 14'h2A5C}, 16);
      chk({m[1:0], 14'h2A5C});
    end
    chk_counts(4, 0);
  endtask
  task t_abort;
    host.send(16'hFFFF, 9);
    chk(16'hEA5C);
    host.send(16'h0000, 15);
    chk(16'hEA5C);
    chk_counts(4, 2);
    host.send(16'h1234, 16);
    chk(16'h1234);
    chk_counts(5, 2);
  endtask
  task t_overrun;
    host.send(16'h5555, 20);
    chk(16'h5555);
    chk_counts(6, 2);
  endtask
  task t_reset;
    host.send(16'h3FFF, 16);
    chk(16'h3FFF);
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(16'h0000);
    host.send(16'h8001, 16);
    chk(16'h8001);
    chk_counts(8, 2);
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    #300 chk(16'h0000);
    t_modes;
    t_abort;
    t_overrun;
    t_reset;
    end_of_test;
  end
  initial begin
    #150000 failures++;
    end_of_test;
  end
endmodule
bind dac_serial_write_port dac_serial_write_port_assertions chk_i (.*);
`default_nettype wire
